// >>> shared/sar_adc_pkg.sv
package sar_adc_pkg;

  localparam int unsigned RESULT_WIDTH  = 8;
  localparam int unsigned TAP_COUNT     = 256;
  localparam int unsigned BIT_IDX_WIDTH = 3;
  localparam int unsigned MSB_INDEX     = 7;

  // Conversion time and clock rate as figures, cycles derived from them
  localparam int unsigned CONV_TIME_NS   = 40000;
  localparam int unsigned CLK_FREQ_MHZ   = 200;
  localparam int unsigned CONV_CYCLES    = CONV_TIME_NS * CLK_FREQ_MHZ / 1000;

  // One sample slot, eight trial slots, one transfer slot
  localparam int unsigned SLOT_COUNT     = 10;

  localparam logic [7:0]  RESULT_RESET   = 8'h00;
  localparam logic [7:0]  SAR_CLEAR      = 8'h00;
  localparam logic [7:0]  SAR_FIRST_TRY  = 8'h80;
  localparam logic        CHANNEL_RESET  = 1'b0;

  typedef enum logic [1:0] {
    SAMPLE,
    TRIAL,
    TRANSFER
  } conv_state_e;

endpackage : sar_adc_pkg

// >>> hw/sar_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Divides the system clock into equal conversion slots
module sar_slot_timer #(
  parameter int unsigned SLOT_CYCLES = 800
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic restart,
  output var  logic slotTick
);

  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } timer_s;

  timer_s state_q;
  timer_s state_d;

  always_comb begin
    state_d      = state_q;
    state_d.tick = 1'b0;
    if (restart) begin
      // The restart cycle counts as the first one of the slot, so a
      // conversion from a select spans exactly ten slots
      state_d.count = 32'h0000_0001;
    end else if (state_q.count == 32'(SLOT_CYCLES - 1)) begin
      state_d.count = 32'h0000_0000;
      state_d.tick  = 1'b1;
    end else begin
      state_d.count = state_q.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= '{count: 32'h0000_0001, tick: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign slotTick = state_q.tick;

endmodule : sar_slot_timer

`default_nettype wire

// >>> hw/sar_adc_control.sv
// Notes on behaviour
// - Two analog channels; either select switches channel and restarts.
// - A valid result for the new channel is ready one whole conversion (ten slots) after a select; until then the old result stays.
// - Conversions repeat back to back so, unless a select restarts the conversion, a result is never older than 40 us.
// - The trial code is decoded to one of 256 ladder taps sent to the comparator.
// - Eight comparator decisions in hardware, then the byte goes to the result register.
// - A read copies the result register out and leaves the conversion alone.
// - Results are 8-bit unsigned codes, one per reference step.
// - One whole conversion, sample to transfer, takes 40 us.
// - The input is held once at the end of each conversion's sample slot for all eight compares.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_control #(
  parameter int unsigned CONV_CYCLES = sar_adc_pkg::CONV_CYCLES
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                select_analog_channel_zero,
  input  wire logic                select_analog_channel_one,
  input  wire logic                read_conversion_result,
  input  wire logic                compAboveAsync,
  output var  logic [7:0]          accumulatorData,
  output var  logic                accumulatorLoad,
  output var  logic                channelSelect,
  output var  logic                sampleTrack,
  output var  logic [255:0]        tapSelect,
  output var  logic                conversionDone
);

  localparam int unsigned SLOT_CYCLES =
    CONV_CYCLES / sar_adc_pkg::SLOT_COUNT;

  typedef struct packed {
    sar_adc_pkg::conv_state_e phase;
    logic [2:0]               bitIdx;
    logic [7:0]               sar;
    logic [7:0]               conversion_result_register;
    logic [7:0]               accData;
    logic                     accLoad;
    logic                     channel;
    logic                     track;
    logic [255:0]             tap;
    logic                     done;
    logic                     compMeta;
    logic                     compSync;
  } adc_s;

  adc_s state_q;
  adc_s state_d;
  logic restart;
  logic slotTick;

  // One-hot ladder tap for a trial code
  function automatic logic [255:0] decodeTap(input logic [7:0] code);
    logic [255:0] oneHot;
    oneHot       = '0;
    oneHot[code] = 1'b1;
    return oneHot;
  endfunction : decodeTap

  assign restart = select_analog_channel_zero | select_analog_channel_one;

  sar_slot_timer #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) slotTimer (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .restart  (restart),
    .slotTick (slotTick)
  );

  always_comb begin
    state_d          = state_q;
    state_d.accLoad  = 1'b0;
    state_d.done     = 1'b0;
    // Comparator is asynchronous to clk_sys
    state_d.compMeta = compAboveAsync;
    state_d.compSync = state_q.compMeta;

    // Read only copies out; no conversion state is touched
    if (read_conversion_result) begin
      state_d.accData = state_q.conversion_result_register;
      state_d.accLoad = 1'b1;
    end

    if (restart) begin
      // Channel one wins if both selects arrive together
      state_d.channel = select_analog_channel_one;
      state_d.phase   = sar_adc_pkg::SAMPLE;
      state_d.track   = 1'b1;
      state_d.sar     = sar_adc_pkg::SAR_CLEAR;
      state_d.bitIdx  = 3'(sar_adc_pkg::MSB_INDEX);
      // Old result kept across restart
    end else if (slotTick) begin
      case (state_q.phase)
        sar_adc_pkg::SAMPLE: begin
          state_d.track  = 1'b0;
          state_d.phase  = sar_adc_pkg::TRIAL;
          state_d.bitIdx = 3'(sar_adc_pkg::MSB_INDEX);
          state_d.sar    = sar_adc_pkg::SAR_FIRST_TRY;
        end
        sar_adc_pkg::TRIAL: begin
          // Comparator settled over the slot; decide at its end
          if (!state_q.compSync) begin
            state_d.sar[state_q.bitIdx] = 1'b0;
          end
          if (state_q.bitIdx == 3'h0) begin
            state_d.phase = sar_adc_pkg::TRANSFER;
          end else begin
            state_d.bitIdx                   = state_q.bitIdx - 3'h1;
            state_d.sar[state_q.bitIdx - 3'h1] = 1'b1;
          end
        end
        sar_adc_pkg::TRANSFER: begin
          state_d.conversion_result_register = state_q.sar;
          state_d.done  = 1'b1;
          // Next conversion starts at once with no command
          state_d.phase = sar_adc_pkg::SAMPLE;
          state_d.track = 1'b1;
          state_d.sar   = sar_adc_pkg::SAR_CLEAR;
        end
        default: begin
          state_d.phase = sar_adc_pkg::SAMPLE;
          state_d.track = 1'b1;
        end
      endcase
    end

    state_d.tap = decodeTap(state_d.sar);
  end

  // Ten slots of CONV_CYCLES/10 give one conversion per 40 us
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q                            <= '0;
      state_q.phase                      <= sar_adc_pkg::SAMPLE;
      state_q.track                      <= 1'b1;
      state_q.channel                    <= sar_adc_pkg::CHANNEL_RESET;
      state_q.conversion_result_register <= sar_adc_pkg::RESULT_RESET;
      state_q.tap                        <= 256'h1;
    end else begin
      state_q <= state_d;
    end
  end

  assign accumulatorData = state_q.accData;
  assign accumulatorLoad = state_q.accLoad;
  assign channelSelect   = state_q.channel;
  assign sampleTrack     = state_q.track;
  assign tapSelect       = state_q.tap;
  assign conversionDone  = state_q.done;

endmodule : sar_adc_control

`default_nettype wire

// >>> testbench/analog_source.sv
`timescale 1ns/1ps
`default_nettype none

module analog_source (
  input  wire logic         clk_sys,
  input  wire logic         channelSelect,
  input  wire logic         sampleTrack,
  input  wire logic [255:0] tapSelect,
  input  wire logic [7:0]   level0,
  input  wire logic [7:0]   level1,
  output var  logic         compAboveAsync
);
  logic [7:0] held = 8'h00;
  int         tap;
  // Cap follows the muxed input only while tracking, then holds
  always @(posedge clk_sys) if (sampleTrack) held <= channelSelect ? level1 : level0;
  // Ties compare high, matching the keep rule of the register
  always_comb begin
    tap = 0;
    for (int k = 0; k < 256; k++) if (tapSelect[k]) tap = k;
    compAboveAsync = int'(held) >= tap;
  end
endmodule : analog_source

`default_nettype wire

// >>> testbench/sar_adc_control_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_control_sva #(
  parameter int unsigned CONV_CYCLES = 8000
) (
  input wire logic         clk_sys,
  input wire logic         reset,
  input wire logic         select_analog_channel_zero,
  input wire logic         select_analog_channel_one,
  input wire logic         read_conversion_result,
  input wire logic [7:0]   accumulatorData,
  input wire logic         accumulatorLoad,
  input wire logic         channelSelect,
  input wire logic         sampleTrack,
  input wire logic [255:0] tapSelect,
  input wire logic         conversionDone
);
  logic        anySel;
  logic [15:0] gap_q;
  logic        restartSeen_q;
  assign anySel = select_analog_channel_zero | select_analog_channel_one;
  // A restart lines up with a done pulse one cycle later
  always_ff @(posedge clk_sys) begin
    restartSeen_q <= reset || anySel;
  end
  // Cycles since the last restart or finished conversion
  always_ff @(posedge clk_sys) begin
    if (reset || restartSeen_q || conversionDone) gap_q <= 16'h0000;
    else gap_q <= gap_q + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_read_load: assert property (accumulatorLoad == $past(read_conversion_result))
    else $error("load not one cycle after read");
  a_data_stable: assert property (!accumulatorLoad |-> $stable(accumulatorData))
    else $error("data moved without load");
  a_sel_one: assert property (select_analog_channel_one |=> channelSelect)
    else $error("channel one not selected");
  a_sel_zero: assert property (select_analog_channel_zero && !select_analog_channel_one |=> !channelSelect)
    else $error("channel zero not selected");
  a_sel_track: assert property (anySel |=> sampleTrack && !conversionDone)
    else $error("select did not restart");
  a_tap_onehot: assert property ($onehot(tapSelect))
    else $error("tap not one-hot");
  a_done_period: assert property (conversionDone |-> gap_q == CONV_CYCLES - 1)
    else $error("conversion length wrong");
  a_hold_start: assert property ($fell(sampleTrack) |-> gap_q == CONV_CYCLES / 10 - 1)
    else $error("hold not at slot end");
endmodule : sar_adc_control_sva

bind sar_adc_control sar_adc_control_sva #(.CONV_CYCLES(CONV_CYCLES)) chk (.*);

`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, sel0 = 1'b0, sel1 = 1'b0, rd = 1'b0;
  logic [7:0] lvl0 = 8'h00, lvl1 = 8'h00, accData, prev;
  logic comp, accLoad, chan, track, done;
  logic [255:0] tap;
  int failures = 0, checked = 0, cycles = 0;
  // select code, level 0, level 1, expected result
  logic [7:0] rows [6][4] = '{'{8'h01, 8'h00, 8'hFF, 8'h00},
    '{8'h02, 8'h00, 8'hFF, 8'hFF}, '{8'h01, 8'h80, 8'h01, 8'h80},
    '{8'h03, 8'h12, 8'h7F, 8'h7F}, '{8'h02, 8'h5A, 8'hA5, 8'hA5},
    '{8'h01, 8'h01, 8'hFE, 8'h01}};
  sar_adc_control #(.CONV_CYCLES(100)) dut (.clk_sys(clk_sys), .reset(reset),
    .select_analog_channel_zero(sel0), .select_analog_channel_one(sel1),
    .read_conversion_result(rd), .compAboveAsync(comp),
    .accumulatorData(accData), .accumulatorLoad(accLoad),
    .channelSelect(chan), .sampleTrack(track), .tapSelect(tap),
    .conversionDone(done));
  analog_source src (.clk_sys(clk_sys), .channelSelect(chan),
    .sampleTrack(track), .tapSelect(tap), .level0(lvl0), .level1(lvl1),
    .compAboveAsync(comp));
  always #2.5 clk_sys = ~clk_sys;
  task automatic summarize();
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk8
  task automatic chkBit(string nm, logic e, logic s);
    chk8(nm, {7'h00, e}, {7'h00, s});
  endtask : chkBit
  task automatic waitDone();
    do begin
      tick(1);
      #1;
    end while (done !== 1'b1);
  endtask : waitDone
  // Load is registered, so look one settle step after the taking edge
  task automatic readBack(logic [7:0] e);
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    #1;
    chkBit("load", 1'b1, accLoad);
    chk8("result", e, accData);
  endtask : readBack
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    tick(5);
    reset <= 1'b0;
    tick(1);
    #1;
    chk8("acc", 8'h00, accData);
    chkBit("track", 1'b1, track);
    chkBit("tap0", 1'b1, tap[0]);
    prev = 8'h00;
    for (int i = 0; i < 6; i++) begin
      lvl0 <= rows[i][1];
      lvl1 <= rows[i][2];
      {sel1, sel0} <= rows[i][0][1:0];
      tick(1);
      {sel1, sel0} <= 2'b00;
      readBack(prev);
      chkBit("chan", rows[i][0][1], chan);
      waitDone();
      readBack(rows[i][3]);
      prev = rows[i][3];
    end
    // Input moves after the hold: this result keeps the old sample
    sel0 <= 1'b1;
    tick(1);
    sel0 <= 1'b0;
    tick(20);
    lvl0 <= 8'hC3;
    waitDone();
    readBack(8'h01);
    waitDone();
    readBack(8'hC3);
    // Reset in mid-run returns channel and result to their reset values
    sel1 <= 1'b1;
    tick(1);
    sel1 <= 1'b0;
    tick(3);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    #1;
    chkBit("chanRst", 1'b0, chan);
    chkBit("trackRst", 1'b1, track);
    readBack(8'h00);
    summarize();
  end
endmodule : tb_top

`default_nettype wire
